// >>> mpgb_regs.svh
// register offsets and reset values for the port block
// assumes word-aligned avalon-mm slave, 32-bit data, byte addresses
`ifndef MPGB_REGS_SVH
`define MPGB_REGS_SVH
`define MPGB_OFS_P2_DIR   6'h00
`define MPGB_OFS_P3_DIR   6'h04
`define MPGB_OFS_P4_DIR   6'h08
`define MPGB_OFS_P12_DIR  6'h0c
`define MPGB_OFS_P2_DAT   6'h10
`define MPGB_OFS_P3_DAT   6'h14
`define MPGB_OFS_P4_DAT   6'h18
`define MPGB_OFS_P12_DAT  6'h1c
`define MPGB_OFS_P13_DAT  6'h20
`define MPGB_OFS_P2_ANA   6'h24
`define MPGB_OFS_P2_PU    6'h28
`define MPGB_OFS_P3_PU    6'h2c
`define MPGB_OFS_P4_PU    6'h30
`define MPGB_OFS_P12_PU   6'h34
`define MPGB_OFS_STATUS   6'h38
`define MPGB_DIR_RST      8'hff
`define MPGB_ANA_RST      8'h00
`define MPGB_PU_RST       8'h00
`define MPGB_DAT_RST      8'h00
`endif

// >>> mpgb_pkg.sv
// types for the multi-port gpio block
// assumes mpgb_regs.svh carries offsets and reset values
package mpgb_pkg;
    typedef enum logic [1:0] {
        MPGB_CLK_INTERNAL = 2'b00,
        MPGB_CLK_CRYSTAL  = 2'b01,
        MPGB_CLK_EXTERNAL = 2'b10
    } mpgb_clk_src_type;
    typedef enum logic [1:0] {
        MPGB_RST_HOLD     = 2'b00,
        MPGB_RST_OPTION   = 2'b01,
        MPGB_RST_RUN      = 2'b10
    } mpgb_rst_state_type;
endpackage

// >>> mpgb_gpio.sv
// multi-port gpio block: ports 2, 3, 4, 12, 13 and shared reset input
// assumes avalon-mm master on core_clk, pins resolved by the bench
//
// What this block does
// - 4-bit port 2 with output latch, per-bit direction and input pull-ups.
// - port 2 pins double as analog converter inputs.
// - reset puts every bit of ports 2, 3, 4, 12 in input mode.
// - 2-bit port 3 with latch, direction, input pull-ups and interrupt use.
// - input-only pin shared with reset; option setting picks port or reset.
// - as general input, the shared pin no longer resets the device.
// - pin low before the option is read keeps the device in reset.
// - 6-bit port 4 with latch, direction, input pull-ups, alternate functions.
// - 3-bit port 12; only its third pin has an option pull-up.
// - internal oscillator frees both oscillator pins as general io.
// - crystal or resonator takes both oscillator pins from general io.
// - external clock takes first oscillator pin; second stays general io.
// - clock source and oscillator pin use come from the option setting.
// - 1-bit output-only port driven by its own data register.
// - output-only pin is low while reset is asserted.
// - four register classes: direction, data, analog mode, pull-up option.
// - direction registers reset to all ones, written only as a whole byte through lane 0.
// - interrupt-shared pin in output mode changing level sets its request.
//
// Decided for this implementation: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`include "mpgb_regs.svh"
module mpgb_gpio (
    input  wire logic                      core_clk,
    input  wire logic                      reset_n,
    input  wire logic [5:0]                avs_address,
    input  wire logic                      avs_read,
    input  wire logic                      avs_write,
    input  wire logic [31:0]               avs_writedata,
    input  wire logic [3:0]                avs_byteenable,
    output logic      [31:0]               avs_readdata,
    output logic                           avs_waitrequest,
    input  wire logic                      option_valid,
    input  wire logic                      option_reset_as_port,
    input  wire mpgb_pkg::mpgb_clk_src_type option_clk_src,
    input  wire logic                      reset_shared_input_pin,
    output logic                           device_reset_n,
    input  wire logic [3:0]                port2_in,
    output logic      [3:0]                port2_out,
    output logic      [3:0]                port2_oe,
    output logic      [3:0]                port2_pullup,
    output logic      [3:0]                port2_analog_en,
    input  wire logic [1:0]                port3_in,
    output logic      [1:0]                port3_out,
    output logic      [1:0]                port3_oe,
    output logic      [1:0]                port3_pullup,
    input  wire logic [5:0]                port4_in,
    output logic      [5:0]                port4_out,
    output logic      [5:0]                port4_oe,
    output logic      [5:0]                port4_pullup,
    input  wire logic [2:0]                port12_in,
    output logic      [2:0]                port12_out,
    output logic      [2:0]                port12_oe,
    output logic      [2:0]                port12_pullup,
    output logic                           oscillator_pins_en,
    output logic                           oscillator_input_en,
    output logic                           output_only_pin,
    output logic      [2:0]                intp_request
);
    import mpgb_pkg::*;

    // pin synchronisers, two flops each
    logic [15:0] pin_meta;
    logic [15:0] pin_sync;
    logic        rst_pin_meta;
    logic        rst_pin_sync;

    logic [7:0]  port2_direction_reg;
    logic [7:0]  port3_direction_reg;
    logic [7:0]  port4_direction_reg;
    logic [7:0]  port12_direction_reg;
    logic [3:0]  port2_data_reg;
    logic [1:0]  port3_data_reg;
    logic [5:0]  port4_data_reg;
    logic [2:0]  port12_data_reg;
    logic        port13_data_reg;
    logic [3:0]  port2_analog_mode_select;
    logic [3:0]  port2_pullup_select;
    logic [1:0]  port3_pullup_select;
    logic [5:0]  port4_pullup_select;
    logic        port12_pullup_select;
    mpgb_rst_state_type rst_state;
    logic        reset_as_port;
    mpgb_clk_src_type clk_src;
    logic        read_ack;
    logic [31:0] rdata;
    logic [2:0]  intp_level_q;

    logic [7:0]  next_port2_direction_reg;
    logic [7:0]  next_port3_direction_reg;
    logic [7:0]  next_port4_direction_reg;
    logic [7:0]  next_port12_direction_reg;
    logic [3:0]  next_port2_data_reg;
    logic [1:0]  next_port3_data_reg;
    logic [5:0]  next_port4_data_reg;
    logic [2:0]  next_port12_data_reg;
    logic        next_port13_data_reg;
    logic [3:0]  next_port2_analog_mode_select;
    logic [3:0]  next_port2_pullup_select;
    logic [1:0]  next_port3_pullup_select;
    logic [5:0]  next_port4_pullup_select;
    logic        next_port12_pullup_select;
    mpgb_rst_state_type next_rst_state;
    logic        next_reset_as_port;
    mpgb_clk_src_type next_clk_src;
    logic        next_read_ack;
    logic [31:0] next_rdata;
    logic [2:0]  intp_level;
    logic [2:0]  p12_gpio_ok;
    logic        latch_write_strobe;
    logic        direction_write_strobe;
    logic        pullup_write_strobe;

    // byte-lane merge of lane 0 into an 8-bit register
    function automatic logic [7:0] merge_byte(input logic [7:0] old_val, input logic [31:0] wd,
                                             input logic [3:0] be);
        merge_byte = be[0] ? wd[7:0] : old_val;
    endfunction

    // read view: pin for inputs, latch for outputs
    function automatic logic [7:0] port_view(input logic [7:0] dir, input logic [7:0] pin,
                                            input logic [7:0] latch);
        port_view = (dir & pin) | (~dir & latch);
    endfunction

    always_ff @(posedge core_clk) begin
        pin_meta     <= {port12_in, port4_in, port3_in, port2_in, 1'b0};
        pin_sync     <= pin_meta;
        rst_pin_meta <= reset_shared_input_pin;
        rst_pin_sync <= rst_pin_meta;
    end

    always_comb begin
        p12_gpio_ok = 3'b111;
        unique case (clk_src)
            MPGB_CLK_CRYSTAL:  p12_gpio_ok = 3'b100;
            MPGB_CLK_EXTERNAL: p12_gpio_ok = 3'b110;
            default:           p12_gpio_ok = 3'b111;
        endcase
    end

    assign latch_write_strobe     = avs_write && (avs_address >= `MPGB_OFS_P2_DAT)
                                    && (avs_address <= `MPGB_OFS_P13_DAT);
    assign direction_write_strobe = avs_write && (avs_address <= `MPGB_OFS_P12_DIR);
    assign pullup_write_strobe    = avs_write && (avs_address >= `MPGB_OFS_P2_PU)
                                    && (avs_address <= `MPGB_OFS_P12_PU);

    always_comb begin
        next_port2_direction_reg      = port2_direction_reg;
        next_port3_direction_reg      = port3_direction_reg;
        next_port4_direction_reg      = port4_direction_reg;
        next_port12_direction_reg     = port12_direction_reg;
        next_port2_data_reg           = port2_data_reg;
        next_port3_data_reg           = port3_data_reg;
        next_port4_data_reg           = port4_data_reg;
        next_port12_data_reg          = port12_data_reg;
        next_port13_data_reg          = port13_data_reg;
        next_port2_analog_mode_select = port2_analog_mode_select;
        next_port2_pullup_select      = port2_pullup_select;
        next_port3_pullup_select      = port3_pullup_select;
        next_port4_pullup_select      = port4_pullup_select;
        next_port12_pullup_select     = port12_pullup_select;
        if (direction_write_strobe || latch_write_strobe || pullup_write_strobe ||
            (avs_write && avs_address == `MPGB_OFS_P2_ANA)) begin
            unique case (avs_address)
                `MPGB_OFS_P2_DIR:  next_port2_direction_reg  = merge_byte(port2_direction_reg, avs_writedata, avs_byteenable);
                `MPGB_OFS_P3_DIR:  next_port3_direction_reg  = merge_byte(port3_direction_reg, avs_writedata, avs_byteenable);
                `MPGB_OFS_P4_DIR:  next_port4_direction_reg  = merge_byte(port4_direction_reg, avs_writedata, avs_byteenable);
                `MPGB_OFS_P12_DIR: next_port12_direction_reg = merge_byte(port12_direction_reg, avs_writedata, avs_byteenable);
                `MPGB_OFS_P2_DAT:  if (avs_byteenable[0]) next_port2_data_reg  = avs_writedata[3:0];
                `MPGB_OFS_P3_DAT:  if (avs_byteenable[0]) next_port3_data_reg  = avs_writedata[1:0];
                `MPGB_OFS_P4_DAT:  if (avs_byteenable[0]) next_port4_data_reg  = avs_writedata[5:0];
                `MPGB_OFS_P12_DAT: if (avs_byteenable[0]) next_port12_data_reg = avs_writedata[3:1];
                `MPGB_OFS_P13_DAT: if (avs_byteenable[0]) next_port13_data_reg = avs_writedata[0];
                `MPGB_OFS_P2_ANA:  if (avs_byteenable[0]) next_port2_analog_mode_select = avs_writedata[3:0];
                `MPGB_OFS_P2_PU:   if (avs_byteenable[0]) next_port2_pullup_select  = avs_writedata[3:0];
                `MPGB_OFS_P3_PU:   if (avs_byteenable[0]) next_port3_pullup_select  = avs_writedata[1:0];
                `MPGB_OFS_P4_PU:   if (avs_byteenable[0]) next_port4_pullup_select  = avs_writedata[5:0];
                `MPGB_OFS_P12_PU:  if (avs_byteenable[0]) next_port12_pullup_select = avs_writedata[3];
                default: ;
            endcase
        end
    end

    always_comb begin
        next_read_ack = avs_read && !read_ack;
        next_rdata    = 32'h0000_0000;
        unique case (avs_address)
            `MPGB_OFS_P2_DIR:  next_rdata[7:0] = port2_direction_reg;
            `MPGB_OFS_P3_DIR:  next_rdata[7:0] = port3_direction_reg;
            `MPGB_OFS_P4_DIR:  next_rdata[7:0] = port4_direction_reg;
            `MPGB_OFS_P12_DIR: next_rdata[7:0] = port12_direction_reg;
            `MPGB_OFS_P2_DAT:  next_rdata[7:0] = port_view(port2_direction_reg,
                                   {4'h0, pin_sync[4:1]}, {4'h0, port2_data_reg}) & 8'h0f;
            `MPGB_OFS_P3_DAT:  next_rdata[7:0] = (port_view(port3_direction_reg,
                                   {6'h00, pin_sync[6:5]}, {6'h00, port3_data_reg}) & 8'h03)
                                   | {3'h0, rst_pin_sync & reset_as_port, 4'h0};
            `MPGB_OFS_P4_DAT:  next_rdata[7:0] = port_view(port4_direction_reg,
                                   {2'h0, pin_sync[12:7]}, {2'h0, port4_data_reg}) & 8'h3f;
            `MPGB_OFS_P12_DAT: next_rdata[7:0] = port_view(port12_direction_reg,
                                   {4'h0, pin_sync[15:13], 1'b0}, {4'h0, port12_data_reg, 1'b0})
                                   & {4'h0, p12_gpio_ok, 1'b0};
            `MPGB_OFS_P13_DAT: next_rdata[0]   = port13_data_reg;
            `MPGB_OFS_P2_ANA:  next_rdata[3:0] = port2_analog_mode_select;
            `MPGB_OFS_P2_PU:   next_rdata[3:0] = port2_pullup_select;
            `MPGB_OFS_P3_PU:   next_rdata[1:0] = port3_pullup_select;
            `MPGB_OFS_P4_PU:   next_rdata[5:0] = port4_pullup_select;
            `MPGB_OFS_P12_PU:  next_rdata[3]   = port12_pullup_select;
            `MPGB_OFS_STATUS:  next_rdata[3:0] = {clk_src, reset_as_port, rst_pin_sync};
            default:           next_rdata      = 32'h0000_0000;
        endcase
    end

    always_comb begin
        next_rst_state     = rst_state;
        next_reset_as_port = reset_as_port;
        next_clk_src       = clk_src;
        unique case (rst_state)
            MPGB_RST_HOLD:   next_rst_state = MPGB_RST_OPTION;
            MPGB_RST_OPTION: if (option_valid && rst_pin_sync) begin
                next_rst_state     = MPGB_RST_RUN;
                next_reset_as_port = option_reset_as_port;
                next_clk_src       = option_clk_src;
            end
            // reset pin only acts while it is the reset function
            MPGB_RST_RUN:    if (!reset_as_port && !rst_pin_sync) next_rst_state = MPGB_RST_HOLD;
            default:         next_rst_state = MPGB_RST_HOLD;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            port2_direction_reg      <= `MPGB_DIR_RST;
            port3_direction_reg      <= `MPGB_DIR_RST;
            port4_direction_reg      <= `MPGB_DIR_RST;
            port12_direction_reg     <= `MPGB_DIR_RST;
            port2_data_reg           <= 4'h0;
            port3_data_reg           <= 2'h0;
            port4_data_reg           <= 6'h00;
            port12_data_reg          <= 3'h0;
            port13_data_reg          <= 1'b0;
            port2_analog_mode_select <= 4'h0;
            port2_pullup_select      <= 4'h0;
            port3_pullup_select      <= 2'h0;
            port4_pullup_select      <= 6'h00;
            port12_pullup_select     <= 1'b0;
            rst_state                <= MPGB_RST_HOLD;
            reset_as_port            <= 1'b0;
            clk_src                  <= MPGB_CLK_INTERNAL;
            read_ack                 <= 1'b0;
            rdata                    <= 32'h0000_0000;
            intp_level_q             <= 3'h0;
        end else begin
            port2_direction_reg      <= next_port2_direction_reg;
            port3_direction_reg      <= next_port3_direction_reg;
            port4_direction_reg      <= next_port4_direction_reg;
            port12_direction_reg     <= next_port12_direction_reg;
            port2_data_reg           <= next_port2_data_reg;
            port3_data_reg           <= next_port3_data_reg;
            port4_data_reg           <= next_port4_data_reg;
            port12_data_reg          <= next_port12_data_reg;
            port13_data_reg          <= next_port13_data_reg;
            port2_analog_mode_select <= next_port2_analog_mode_select;
            port2_pullup_select      <= next_port2_pullup_select;
            port3_pullup_select      <= next_port3_pullup_select;
            port4_pullup_select      <= next_port4_pullup_select;
            port12_pullup_select     <= next_port12_pullup_select;
            rst_state                <= next_rst_state;
            reset_as_port            <= next_reset_as_port;
            clk_src                  <= next_clk_src;
            read_ack                 <= next_read_ack;
            rdata                    <= next_rdata;
            intp_level_q             <= intp_level;
        end
    end

    assign avs_waitrequest = avs_read && !read_ack;
    assign avs_readdata    = rdata;
    assign device_reset_n  = (rst_state == MPGB_RST_RUN);

    assign port2_out       = port2_data_reg;
    assign port2_oe        = ~port2_direction_reg[3:0] & ~port2_analog_mode_select;
    assign port2_analog_en = port2_analog_mode_select;
    assign port2_pullup    = port2_pullup_select & port2_direction_reg[3:0] & ~port2_analog_mode_select;
    assign port3_out       = port3_data_reg;
    assign port3_oe        = ~port3_direction_reg[1:0];
    assign port3_pullup    = port3_pullup_select & port3_direction_reg[1:0];
    assign port4_out       = port4_data_reg;
    assign port4_oe        = ~port4_direction_reg[5:0];
    assign port4_pullup    = port4_pullup_select & port4_direction_reg[5:0];
    assign port12_out      = port12_data_reg;
    assign port12_oe       = ~port12_direction_reg[3:1] & p12_gpio_ok;
    assign port12_pullup   = {port12_pullup_select & port12_direction_reg[3], 2'b00};
    assign oscillator_pins_en  = (clk_src == MPGB_CLK_CRYSTAL);
    assign oscillator_input_en = (clk_src != MPGB_CLK_INTERNAL);
    assign output_only_pin = port13_data_reg;

    // output-mode level change raises interrupt request
    assign intp_level   = {port4_data_reg[3], port3_data_reg};
    assign intp_request = (intp_level ^ intp_level_q)
                          & {~port4_direction_reg[3], ~port3_direction_reg[1:0]};

    a_out_only_reset: assert property (@(posedge core_clk) !reset_n |=> !output_only_pin)
        else $error("output-only pin not low after reset");
    a_dir_reset_ones: assert property (@(posedge core_clk) !reset_n |=> (port4_direction_reg == 8'hff))
        else $error("direction not all ones after reset");
    // no pull-up on an output bit
    a_pullup_output_off: assert property (@(posedge core_clk) disable iff (!reset_n)
        (port4_oe & port4_pullup) == 6'h00)
        else $error("pull-up on output bit");
    a_crystal_pins_held: assert property (@(posedge core_clk) disable iff (!reset_n)
        (clk_src == MPGB_CLK_CRYSTAL) |-> (port12_oe[1:0] == 2'b00))
        else $error("oscillator pin driven with crystal");
    // reset held while pin low before option
    a_reset_hold_pin: assert property (@(posedge core_clk) disable iff (!reset_n)
        (rst_state == MPGB_RST_OPTION && !rst_pin_sync) |=> !device_reset_n)
        else $error("reset released with pin low");
    a_port_no_reset: assert property (@(posedge core_clk) disable iff (!reset_n)
        (device_reset_n && reset_as_port) |=> device_reset_n)
        else $error("port-mode pin caused reset");
    a_read_latch: assert property (@(posedge core_clk) disable iff (!reset_n)
        (avs_read && !read_ack && avs_address == `MPGB_OFS_P13_DAT) |=> (avs_readdata[0] == output_only_pin))
        else $error("latch readback wrong");
    a_intp_on_change: assert property (@(posedge core_clk) disable iff (!reset_n)
        (!port3_direction_reg[0] && $changed(port3_data_reg[0]) && $stable(port3_direction_reg[0]))
        |-> intp_request[0])
        else $error("no interrupt on output change");
endmodule

// >>> mpgb_pin_model.sv
// pad model for the gpio block: resolves each pin from driver, board and pull-up
// assumes the bench drives ext and ext_en for the board side
`timescale 1ns/1ps
module mpgb_pin_model #(parameter int W = 4) (
    input  wire logic         core_clk,
    input  wire logic [W-1:0] out,
    input  wire logic [W-1:0] oe,
    input  wire logic [W-1:0] pu_en,
    input  wire logic [W-1:0] ext,
    input  wire logic [W-1:0] ext_en,
    output logic      [W-1:0] pad
);
    logic [W-1:0] last = '0;
    // floating pad shows the inverse of its last driven level
    always @(posedge core_clk) last <= (pad & (oe | ext_en)) | (last & ~(oe | ext_en));
    always_comb begin
        for (int i = 0; i < W; i++) begin
            pad[i] = oe[i] ? out[i] : ext_en[i] ? ext[i] : pu_en[i] ? 1'b1 : ~last[i];
        end
    end
endmodule

// >>> mpgb_gpio_bench.sv
// bench for the gpio block: avalon-mm register tasks and port checks
// assumes mpgb_pin_model stands in for the pads
`timescale 1ns/1ps
`include "mpgb_regs.svh"
module mpgb_gpio_bench;
    import mpgb_pkg::*;
    logic core_clk = 0, reset_n = 0, avs_read = 0, avs_write = 0, avs_waitrequest;
    logic [5:0] avs_address = '0;
    logic [31:0] avs_writedata = '0, avs_readdata;
    logic [3:0] avs_byteenable = 4'h1, port2_in, port2_out, port2_oe, port2_pullup, port2_analog_en;
    logic [3:0] ext2 = '0, xen2 = '0;
    logic [1:0] ext3 = '0, xen3 = 2'h3;
    logic [5:0] ext4 = 6'h15, xen4 = 6'h3f;
    logic [2:0] ext12 = 3'h5, xen12 = 3'h7;
    logic [1:0] port3_in, port3_out, port3_oe, port3_pullup;
    logic [5:0] port4_in, port4_out, port4_oe, port4_pullup;
    logic [2:0] port12_in, port12_out, port12_oe, port12_pullup, intp_request;
    logic option_valid = 1, option_reset_as_port = 0, reset_shared_input_pin = 1, device_reset_n;
    logic oscillator_pins_en, oscillator_input_en, output_only_pin;
    mpgb_clk_src_type option_clk_src = MPGB_CLK_INTERNAL;
    int err_total = 0, tests_run = 0, pulses = 0;
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) if (intp_request[0] === 1'b1) pulses++;
    mpgb_gpio dut (.core_clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .option_valid, .option_reset_as_port,
        .option_clk_src, .reset_shared_input_pin, .device_reset_n, .port2_in, .port2_out, .port2_oe,
        .port2_pullup, .port2_analog_en, .port3_in, .port3_out, .port3_oe, .port3_pullup, .port4_in,
        .port4_out, .port4_oe, .port4_pullup, .port12_in, .port12_out, .port12_oe, .port12_pullup,
        .oscillator_pins_en, .oscillator_input_en, .output_only_pin, .intp_request);
    mpgb_pin_model #(.W(4)) m2 (.core_clk, .out(port2_out), .oe(port2_oe), .pu_en(port2_pullup),
        .ext(ext2), .ext_en(xen2), .pad(port2_in));
    mpgb_pin_model #(.W(2)) m3 (.core_clk, .out(port3_out), .oe(port3_oe), .pu_en(port3_pullup),
        .ext(ext3), .ext_en(xen3), .pad(port3_in));
    mpgb_pin_model #(.W(6)) m4 (.core_clk, .out(port4_out), .oe(port4_oe), .pu_en(port4_pullup),
        .ext(ext4), .ext_en(xen4), .pad(port4_in));
    mpgb_pin_model #(.W(3)) m12 (.core_clk, .out(port12_out), .oe(port12_oe), .pu_en(port12_pullup),
        .ext(ext12), .ext_en(xen12), .pad(port12_in));
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        @(negedge core_clk);
        while (avs_waitrequest !== 1'b0 && n < 20) begin
            n++;
            @(negedge core_clk);
        end
        if (n == 20) begin
            err_total++;
            give_verdict();
        end
        @(posedge core_clk);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(negedge core_clk);
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, {24'h0, d}, q);
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] e, input string n);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(n, e, q);
    endtask
    task automatic do_reset(input mpgb_clk_src_type s, input logic as_port, input logic ok);
        @(posedge core_clk);
        option_clk_src <= s;
        option_reset_as_port <= as_port;
        option_valid <= ok;
        reset_n <= 1'b0;
        repeat (10) @(posedge core_clk);
        @(negedge core_clk);
        check("oe in reset", 32'h0, {port2_oe, port3_oe, port4_oe, port12_oe});
        check("p13 in reset", 32'h0, output_only_pin);
        @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (6) @(negedge core_clk);
    endtask
    initial begin
        do_reset(MPGB_CLK_INTERNAL, 1'b0, 1'b1);
        for (int i = 0; i < 4; i++) rd(6'(4 * i), 32'hff, "dir reset");
        wr(`MPGB_OFS_P2_DAT, 8'h05);
        wr(`MPGB_OFS_P2_DIR, 8'hf0);
        check("p2 oe", 32'hf, port2_oe);
        check("p2 out", 32'h5, port2_out);
        rd(`MPGB_OFS_P2_DAT, 32'h05, "p2 latch read");
        wr(`MPGB_OFS_P2_DIR, 8'hff);
        @(posedge core_clk);
        ext2 <= 4'ha;
        xen2 <= 4'hf;
        repeat (2) @(posedge core_clk);
        rd(`MPGB_OFS_P2_DAT, 32'h0a, "p2 pin read");
        wr(`MPGB_OFS_P2_PU, 8'h0f);
        wr(`MPGB_OFS_P2_DIR, 8'hfe);
        check("p2 pullup", 32'he, port2_pullup);
        wr(`MPGB_OFS_P2_ANA, 8'h02);
        check("p2 analog", 32'h2, port2_analog_en);
        check("p2 pullup ana", 32'hc, port2_pullup);
        wr(`MPGB_OFS_P3_DIR, 8'hfe);
        check("p3 oe", 32'h1, port3_oe);
        wr(`MPGB_OFS_P3_DAT, 8'h01);
        repeat (2) @(negedge core_clk);
        check("intp pulses", 32'h1, pulses);
        check("p3 out", 32'h1, port3_out);
        rd(`MPGB_OFS_P4_DAT, 32'h15, "p4 pin read");
        wr(`MPGB_OFS_P4_DIR, 8'hc0);
        check("p4 oe", 32'h3f, port4_oe);
        wr(`MPGB_OFS_P4_DAT, 8'h25);
        check("p4 out", 32'h25, port4_out);
        wr(`MPGB_OFS_P12_PU, 8'h0e);
        check("p12 pullup", 32'h4, port12_pullup);
        rd(6'h3c, 32'h0, "unmapped");
        wr(`MPGB_OFS_P13_DAT, 8'h01);
        check("p13 out", 32'h1, output_only_pin);
        @(posedge core_clk);
        avs_byteenable <= 4'h0;
        wr(`MPGB_OFS_P13_DAT, 8'h00);
        @(posedge core_clk);
        avs_byteenable <= 4'h1;
        check("p13 lane off", 32'h1, output_only_pin);
        for (int s = 0; s < 3; s++) begin
            do_reset(mpgb_clk_src_type'(s), 1'b0, 1'b1);
            rd(`MPGB_OFS_P12_DAT, s == 0 ? 32'h0a : 32'h08, "p12 pin read");
            wr(`MPGB_OFS_P12_DIR, 8'hf1);
            check("osc pins", 32'(s == 1), oscillator_pins_en);
            check("p12 oe", s == 0 ? 32'h7 : s == 1 ? 32'h4 : 32'h6, port12_oe);
            if (s == 2) check("osc input", 32'h1, oscillator_input_en);
        end
        @(posedge core_clk);
        reset_shared_input_pin <= 1'b0;
        repeat (5) @(negedge core_clk);
        check("pin as reset", 32'h0, device_reset_n);
        @(posedge core_clk);
        reset_shared_input_pin <= 1'b1;
        repeat (6) @(negedge core_clk);
        check("pin released", 32'h1, device_reset_n);
        do_reset(MPGB_CLK_INTERNAL, 1'b1, 1'b1);
        @(posedge core_clk);
        reset_shared_input_pin <= 1'b0;
        repeat (5) @(negedge core_clk);
        check("pin as port", 32'h1, device_reset_n);
        rd(`MPGB_OFS_P3_DAT, 32'h00, "p3 pin4 read");
        @(posedge core_clk);
        reset_shared_input_pin <= 1'b1;
        repeat (2) @(posedge core_clk);
        rd(`MPGB_OFS_P3_DAT, 32'h10, "p3 pin4 high");
        rd(`MPGB_OFS_STATUS, 32'h3, "status");
        do_reset(MPGB_CLK_INTERNAL, 1'b0, 1'b0);
        check("no option", 32'h0, device_reset_n);
        give_verdict();
    end
endmodule
